// File: verilog/fhp_pkg.sv
// package for the flash host pin controller
// assumes one 40 MHz clock; the flash itself is driven through pins only
package fhp_pkg;
  localparam int CLK_MHZ = 40;
  // strobe phase widths in ns, converted to whole cycles (round up)
  localparam int STROBE_NS = 50;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] STROBE_CNT = 4'(STROBE_CYC < 1 ? 1 : STROBE_CYC);
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] CONFIRM_PROG = 8'h40;
  localparam logic [7:0] CONFIRM_ERASE = 8'hb0;
  localparam logic [11:0] VALID_COL_FIRST = 12'h800;
  localparam logic [11:0] VALID_COL_LAST = 12'h83f;
  localparam logic [3:0] CNT_RESET = 4'h0;
  // host command kinds on the user port
  typedef enum logic [2:0] {
    FHP_OP_CMD, FHP_OP_ADDR, FHP_OP_WDATA, FHP_OP_RDATA, FHP_OP_STATUS,
    FHP_OP_IDLE
  } fhp_op_t;
endpackage : fhp_pkg

// File: verilog/fhp_fifo.sv
// small synchronous fifo, flip-flop storage
// assumes both sides on the same clock; ce freezes all state
`timescale 1ns/100ps
module fhp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = (AW+1)'(count + 1'b1);
    end else if (pop && !push) begin
      next_count = (AW+1)'(count - 1'b1);
    end
  end

  assign in_ready = ce && (count != (AW+1)'(DEPTH));
  assign out_valid = ce && (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage has no reset; contents are only read below count
  always_ff @(posedge clock) begin
    if (ce && push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : fhp_fifo

// File: verilog/fhp_host.sv
// host-side controller that drives the flash pins byte by byte
// assumes the flash pins are asynchronous to clock; inputs are synchronised
`timescale 1ns/100ps
module fhp_host
  import fhp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic power_ok,
  input wire logic req_valid,
  output logic req_ready,
  input wire fhp_op_t req_op,
  input wire logic [7:0] req_data,
  input wire logic req_last,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data,
  output logic busy,
  output logic chip_sel_n,
  output logic out_gate_n,
  output logic write_n,
  output logic serial_strobe,
  output logic cmd_addr_select_n,
  output logic power_guard_n,
  output logic [7:0] byte_bus_out,
  output logic byte_bus_oe,
  input wire logic [7:0] byte_bus_in,
  input wire logic ready_busy_n_in
);
  typedef enum logic [2:0] {
    FHP_IDLE, FHP_SETUP, FHP_STROBE, FHP_HOLD, FHP_SAMPLE, FHP_LAUNCH
  } fhp_state_t;

  fhp_state_t state, next_state;
  fhp_op_t op, next_op;
  logic [3:0] cnt, next_cnt;
  logic [7:0] dout, next_dout;
  logic [7:0] rbyte, next_rbyte;
  logic sel, next_sel;
  logic last, next_last;
  logic oe, next_oe;
  logic gate, next_gate;
  logic wstb, next_wstb;
  logic sstb, next_sstb;
  logic push, next_push;
  logic launched, next_launched;
  logic guard, next_guard;
  logic [7:0] bus_s1, bus_s2;
  logic rb_s1, rb_s2;
  logic pok_s1, pok_s2;
  logic f_in_ready, f_out_valid;
  logic [7:0] f_out_data;
  logic fifo_push_ok;

  // read data returns through a fifo so a slow consumer stalls the strobe
  fhp_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data(rbyte),
    .out_valid(f_out_valid),
    .out_ready(rd_ready),
    .out_data(f_out_data)
  );
  assign rd_valid = f_out_valid;
  assign rd_data = f_out_data;
  assign fifo_push_ok = f_in_ready;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_s1 <= 8'h00;
      bus_s2 <= 8'h00;
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
      pok_s1 <= 1'b0;
      pok_s2 <= 1'b0;
    end else if (ce) begin
      bus_s1 <= byte_bus_in;
      bus_s2 <= bus_s1;
      rb_s1 <= ready_busy_n_in;
      rb_s2 <= rb_s1;
      pok_s1 <= power_ok;
      pok_s2 <= pok_s1;
    end
  end

  function automatic logic is_confirm(input fhp_op_t o, input logic [7:0] d);
    is_confirm = (o == FHP_OP_CMD) &&
                 (d == CONFIRM_PROG || d == CONFIRM_ERASE);
  endfunction : is_confirm

  // strobe-class ops use the serial strobe, command and address the write strobe; status uses neither
  function automatic logic is_serial(input fhp_op_t o);
    is_serial = (o == FHP_OP_WDATA) || (o == FHP_OP_RDATA);
  endfunction : is_serial

  always_comb begin
    next_state = state;
    next_op = op;
    next_cnt = cnt;
    next_dout = dout;
    next_rbyte = rbyte;
    next_sel = sel;
    next_last = last;
    next_oe = oe;
    next_gate = gate;
    next_wstb = wstb;
    next_sstb = sstb;
    next_push = 1'b0;
    next_launched = launched;
    req_ready = 1'b0;
    wr_ready = 1'b0;
    // guard follows the supply; held only while state is not FHP_IDLE, so it can drop while busy or between burst bytes
    next_guard = (pok_s2 || state != FHP_IDLE) ?
                 (pok_s2 || guard) : 1'b0;
    if (!rb_s2) begin
      next_launched = 1'b0;
    end
    case (state)
      FHP_IDLE: begin
        req_ready = ce && guard && !(req_op == FHP_OP_WDATA && !wr_valid);
        if (req_valid && req_ready && req_op != FHP_OP_IDLE) begin
          next_op = req_op;
          next_last = req_last;
          next_sel = (req_op == FHP_OP_ADDR);
          next_dout = (req_op == FHP_OP_WDATA) ? wr_data : req_data;
          wr_ready = (req_op == FHP_OP_WDATA);
          // drive the bus only when the flash is not driving it
          next_oe = (req_op == FHP_OP_CMD) || (req_op == FHP_OP_ADDR) ||
                    (req_op == FHP_OP_WDATA);
          // status and serial read both need the flash's output gate open
          next_gate = (req_op == FHP_OP_STATUS) ||
                      (req_op == FHP_OP_RDATA);
          next_cnt = STROBE_CNT;
          next_state = FHP_SETUP;
        end
      end
      FHP_SETUP: begin
        next_cnt = 4'(cnt - 1'b1);
        if (cnt == 4'h1) begin
          next_cnt = STROBE_CNT;
          if (next_op == FHP_OP_STATUS) begin
            next_state = FHP_SAMPLE;
          end else if (op != FHP_OP_RDATA || fifo_push_ok) begin
            next_wstb = !is_serial(op);
            next_sstb = is_serial(op);
            next_state = FHP_STROBE;
          end else begin
            next_cnt = 4'h1;
          end
        end
      end
      FHP_STROBE: begin
        next_cnt = 4'(cnt - 1'b1);
        if (cnt == 4'h1) begin
          // rising write strobe latches the byte; the serial strobe falls here, having latched on its rise
          next_wstb = 1'b0;
          next_sstb = 1'b0;
          next_cnt = STROBE_CNT;
          next_state = (op == FHP_OP_RDATA) ? FHP_SAMPLE : FHP_HOLD;
        end
      end
      FHP_SAMPLE: begin
        next_cnt = 4'(cnt - 1'b1);
        if (cnt == 4'h1) begin
          next_rbyte = bus_s2;
          next_push = 1'b1;
          next_cnt = STROBE_CNT;
          next_state = FHP_HOLD;
        end
      end
      FHP_HOLD: begin
        next_cnt = 4'(cnt - 1'b1);
        if (cnt == 4'h1) begin
          next_oe = 1'b0;
          next_gate = 1'b0;
          next_state = is_confirm(op, dout) ? FHP_LAUNCH : FHP_IDLE;
          if (is_confirm(op, dout)) begin
            next_launched = 1'b1;
          end
        end
      end
      FHP_LAUNCH: begin
        // return to idle next cycle without waiting for the synchronised busy level
        next_state = FHP_IDLE;
      end
      default: begin
        next_state = FHP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= FHP_IDLE;
      op <= FHP_OP_IDLE;
      cnt <= CNT_RESET;
      dout <= 8'h00;
      rbyte <= 8'h00;
      sel <= 1'b0;
      last <= 1'b1;
      oe <= 1'b0;
      gate <= 1'b0;
      wstb <= 1'b0;
      sstb <= 1'b0;
      push <= 1'b0;
      launched <= 1'b0;
      guard <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      op <= next_op;
      cnt <= next_cnt;
      dout <= next_dout;
      rbyte <= next_rbyte;
      sel <= next_sel;
      last <= next_last;
      oe <= next_oe;
      gate <= next_gate;
      wstb <= next_wstb;
      sstb <= next_sstb;
      push <= next_push;
      launched <= next_launched;
      guard <= next_guard;
    end
  end

  // select stays low until the burst's last byte so a read returns to standby on rise,
  // and stays low while busy so the operation is not disturbed
  always_comb begin
    chip_sel_n = !(state != FHP_IDLE || !last || launched || !rb_s2);
  end
  assign out_gate_n = !gate;
  assign write_n = !wstb;
  assign serial_strobe = sstb;
  assign cmd_addr_select_n = sel;
  assign power_guard_n = guard;
  assign byte_bus_out = dout;
  assign byte_bus_oe = oe;
  assign busy = launched || !rb_s2;
  // the sector valid marker (columns 800..83f) is read and rewritten by the
  // user through ordinary read and program sequences
endmodule : fhp_host

// File: dv/fhp_host_checker.sv
// pin-level assertions on the host controller
// assumes the bind below reaches every fhp_host
`timescale 1ns/100ps
module fhp_host_checker
  import fhp_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic power_ok,
  input wire logic busy,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic write_n,
  input wire logic serial_strobe,
  input wire logic cmd_addr_select_n,
  input wire logic power_guard_n,
  input wire logic [7:0] byte_bus_out,
  input wire logic byte_bus_oe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  chk_guard_needs_power: assert property (
    $rose(power_guard_n) |-> $past(power_ok, 2)) else $error("guard early");
  chk_guard_during_op: assert property (
    !chip_sel_n |-> power_guard_n) else $error("guard low in op");
  chk_cmd_pin_levels: assert property (!write_n |->
    !chip_sel_n && out_gate_n && !serial_strobe && byte_bus_oe)
    else $error("bad write levels");
  chk_no_bus_fight: assert property (
    !out_gate_n |-> !byte_bus_oe) else $error("bus fight");
  chk_select_steady: assert property (
    !write_n && $past(!write_n) |->
    $stable(cmd_addr_select_n) && $stable(byte_bus_out))
    else $error("select moved");
  chk_write_pulse: assert property (
    $fell(write_n) |-> !write_n[*2] ##1 write_n) else $error("write width");
  chk_strobe_pulse: assert property (
    $rose(serial_strobe) |-> serial_strobe[*2] ##1 !serial_strobe)
    else $error("strobe width");
  chk_confirm_busy: assert property ($rose(write_n) &&
    !cmd_addr_select_n && (byte_bus_out == CONFIRM_PROG ||
    byte_bus_out == CONFIRM_ERASE) |-> ##[0:3] busy)
    else $error("no busy");
endmodule : fhp_host_checker
bind fhp_host fhp_host_checker fhp_host_checker_i (.*);

// File: dv/fhp_flash_model.sv
// behavioural flash device on the host pins
// assumes port names match the host so the bench connects by name
`timescale 1ns/100ps
module fhp_flash_model #(
  parameter int BUSY_NS = 2000
) (
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic write_n,
  input wire logic serial_strobe,
  input wire logic cmd_addr_select_n,
  input wire logic power_guard_n,
  input wire logic [7:0] byte_bus_out,
  input wire logic byte_bus_oe,
  output logic [7:0] byte_bus_in,
  output wire logic ready_busy_n_in
);
  logic rb_low = 1'b0;
  logic read_mode = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] dout = 8'h00;
  logic [7:0] last_wr = 8'h00;
  // released line is driven high by the model
  assign ready_busy_n_in = rb_low ? 1'b0 : 1'b1;
  always @(posedge write_n) begin
    if (power_guard_n && !chip_sel_n) begin
      if (cmd_addr_select_n) addr = byte_bus_out;
      else begin
        read_mode = (byte_bus_out == 8'h00);
        if (byte_bus_out == 8'h40 || byte_bus_out == 8'hb0) begin
          rb_low = 1'b1;
          #(BUSY_NS) rb_low = 1'b0;
        end
      end
    end
  end
  always @(posedge serial_strobe) begin
    if (power_guard_n && !chip_sel_n) begin
      if (out_gate_n) last_wr = byte_bus_out;
      else begin
        dout = addr;
        addr = addr + 8'h01;
      end
    end
  end
  always @(posedge chip_sel_n) if (!rb_low) read_mode = 1'b0;
  // status layout chosen here: bit 7 is ready
  always @* begin
    if (byte_bus_oe) byte_bus_in = byte_bus_out;
    else if (power_guard_n && !chip_sel_n && !out_gate_n)
      byte_bus_in = read_mode ? dout : {!rb_low, 7'h00};
    else byte_bus_in = ~byte_bus_out;
  end
endmodule : fhp_flash_model

// File: dv/test_fhp_host.sv
// self-checking bench for the flash host controller
// assumes the flash model sits on the pins; 40 MHz clock
`timescale 1ns/100ps
module test_fhp_host;
  import fhp_pkg::*;
  typedef struct {
    fhp_op_t op;
    logic [7:0] d;
    logic l;
    logic [7:0] e;
  } fhp_row_t;
  logic clock = 1'b0, rst = 1'b1, ce = 1'b1, power_ok = 1'b0;
  logic req_valid = 1'b0, req_last = 1'b0, wr_valid = 1'b0, rd_ready = 1'b0;
  fhp_op_t req_op = FHP_OP_IDLE;
  logic [7:0] req_data = 8'h00, wr_data = 8'h00, rd_data, byte_bus_out;
  logic [7:0] byte_bus_in;
  logic req_ready, wr_ready, rd_valid, busy, chip_sel_n, out_gate_n, write_n;
  logic serial_strobe, cmd_addr_select_n, power_guard_n, byte_bus_oe;
  wire logic ready_busy_n_in;
  int failures = 0, comparisons = 0, cycles = 0;
  fhp_row_t rows [7] = '{
    '{FHP_OP_STATUS, 8'h00, 1'b1, 8'h80},
    '{FHP_OP_CMD, 8'h00, 1'b0, 8'h00},
    '{FHP_OP_ADDR, 8'h08, 1'b0, 8'h00},
    '{FHP_OP_ADDR, 8'h34, 1'b0, 8'h00},
    '{FHP_OP_RDATA, 8'h00, 1'b0, 8'h34},
    '{FHP_OP_RDATA, 8'h00, 1'b1, 8'h35},
    '{FHP_OP_STATUS, 8'h00, 1'b1, 8'h80}
  };
  fhp_host fhp_host_i (.*);
  fhp_flash_model fhp_flash_model_i (.*);
  always #12.5 clock = ~clock;
  task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic step();
    @(posedge clock);
    #2;
  endtask : step
  task automatic req(fhp_op_t op, logic [7:0] d, logic last);
    step();
    req_op = op;
    req_data = d;
    wr_data = d;
    req_last = last;
    req_valid = 1'b1;
    wr_valid = (op == FHP_OP_WDATA);
    while (req_ready !== 1'b1) step();
    chk("wr_ready", {7'h00, wr_ready}, {7'h00, op == FHP_OP_WDATA});
    step();
    req_valid = 1'b0;
    wr_valid = 1'b0;
  endtask : req
  task automatic get(string n, logic [7:0] exp);
    step();
    while (rd_valid !== 1'b1) step();
    chk(n, rd_data, exp);
    rd_ready = 1'b1;
    step();
    rd_ready = 1'b0;
  endtask : get
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  // whole run needs well under this many cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    repeat (16) step();
    rst = 1'b0;
    repeat (4) step();
    chk("guard", {7'h00, power_guard_n}, 8'h00);
    chk("refused", {7'h00, req_ready}, 8'h00);
    power_ok = 1'b1;
    foreach (rows[i]) begin
      req(rows[i].op, rows[i].d, rows[i].l);
      if (rows[i].op inside {FHP_OP_RDATA, FHP_OP_STATUS})
        get("row", rows[i].e);
    end
    // marker column is written by program first, then erased; the model's last_wr is checked against 5c before the erase
    for (int k = 0; k < 2; k++) begin
      req(FHP_OP_CMD, k ? 8'h20 : 8'h10, 1'b0);
      req(FHP_OP_ADDR, 8'h08, 1'b0);
      if (k == 0) req(FHP_OP_WDATA, 8'h5c, 1'b0);
      req(FHP_OP_CMD, k ? CONFIRM_ERASE : CONFIRM_PROG, 1'b1);
      repeat (12) step();
      chk("busy", {7'h00, busy}, 8'h01);
      while (busy === 1'b1) step();
      req(FHP_OP_STATUS, 8'h00, 1'b1);
      get("status", 8'h80);
      if (k == 0) chk("wdata", fhp_flash_model_i.last_wr, 8'h5c);
    end
    // consumer stalls: sixteen bytes fill the queue, the next read waits
    req(FHP_OP_CMD, 8'h00, 1'b0);
    req(FHP_OP_ADDR, 8'h40, 1'b0);
    for (int i = 0; i <= FIFO_DEPTH; i++)
      req(FHP_OP_RDATA, 8'h00, i == FIFO_DEPTH);
    repeat (12) step();
    // with the clock enable low the queue offers nothing and keeps its bytes
    ce = 1'b0;
    repeat (3) step();
    chk("frozen", {7'h00, rd_valid}, 8'h00);
    ce = 1'b1;
    for (int i = 0; i <= FIFO_DEPTH; i++) get("fifo", 8'h40 + 8'(i));
    step();
    chk("drained", {7'h00, rd_valid}, 8'h00);
    // mid-run reset drops the guard, which returns with the supply
    req(FHP_OP_STATUS, 8'h00, 1'b1);
    rst = 1'b1;
    step();
    chk("rst guard", {7'h00, power_guard_n}, 8'h00);
    chk("rst refused", {7'h00, req_ready}, 8'h00);
    chk("rst select", {7'h00, chip_sel_n}, 8'h01);
    rst = 1'b0;
    repeat (4) step();
    chk("guard back", {7'h00, power_guard_n}, 8'h01);
    conclude();
  end
endmodule : test_fhp_host
